// File: design/fdsm_pkg.sv
// fast detect and signal monitor package: register map, fields, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
//
// Functional notes
// RL1: flag pin is driven only while the fast-detect enable bit is 1.
// RL2: 13-bit upper threshold, low byte plus bits 4:0 of next register.
// RL3: 13-bit lower threshold, low byte plus 5-bit high field.
// RL4: 16-bit dwell count; flag clears after magnitude stays below lower that long.
// RL5: sync enable 0 ignores sysref; 1 lets sysref edges align the monitor.
// RL6: next-sync mode uses only the first sysref edge after arming.
// RL7: next-sync mode clears the sync enable bit once that edge arrives.
// RL8: next-sync mode 0 realigns the monitor on every sysref edge.
// RL9: sysref period must be an integer multiple of the monitor period.
// RL10: sysref input path must be enabled before relying on it for sync.
// RL11: peak detector runs only while monitor control bit 1 is set.
// RL12: 24-bit period in output clock cycles; low byte resets to 0x80.
// RL13: only even monitor periods may be programmed; the code also accepts and uses odd periods.
// RL14: force bit makes the flag pin show the force value instead.
// RL15: period bits 15:8 and 23:16 come from the two following bytes.
// RL16: flag sets when magnitude exceeds upper, holds until dwell met.
// RL17: peak detector keeps the largest magnitude per period, restarts at expiry.
package fdsm_pkg;
   // ---------------------------------------------------------------
   // register indexes; byte address is index times four
   // ---------------------------------------------------------------
   localparam logic [11:0] FDSM_IDX_FD_CTRL   = 12'h245;
   localparam logic [11:0] FDSM_IDX_UP_LO     = 12'h247;
   localparam logic [11:0] FDSM_IDX_UP_HI     = 12'h248;
   localparam logic [11:0] FDSM_IDX_LO_LO     = 12'h249;
   localparam logic [11:0] FDSM_IDX_LO_HI     = 12'h24A;
   localparam logic [11:0] FDSM_IDX_DW_LO     = 12'h24B;
   localparam logic [11:0] FDSM_IDX_DW_HI     = 12'h24C;
   localparam logic [11:0] FDSM_IDX_SYNC_CTRL = 12'h26F;
   localparam logic [11:0] FDSM_IDX_MON_CTRL  = 12'h270;
   localparam logic [11:0] FDSM_IDX_PER0      = 12'h271;
   localparam logic [11:0] FDSM_IDX_PER1      = 12'h272;
   localparam logic [11:0] FDSM_IDX_PER2      = 12'h273;
   localparam logic [11:0] FDSM_IDX_PEAK      = 12'h280;
   localparam logic [11:0] FDSM_IDX_IRQ_STAT  = 12'h281;
   localparam logic [11:0] FDSM_IDX_IRQ_EN    = 12'h282;
   localparam logic [11:0] FDSM_IDX_IRQ_CLR   = 12'h283;
   localparam int          FDSM_IDX_W         = 12;
   localparam int          FDSM_ADDR_W        = 14;
   // ---------------------------------------------------------------
   // field positions and widths
   // ---------------------------------------------------------------
   localparam int FDSM_FD_EN_BIT    = 0;
   localparam int FDSM_FORCE_VAL_BIT = 2;
   localparam int FDSM_FORCE_BIT    = 3;
   localparam int FDSM_SYNC_EN_BIT  = 0;
   localparam int FDSM_SYNC_NEXT_BIT = 1;
   localparam int FDSM_PEAK_EN_BIT  = 1;
   localparam int FDSM_THR_W        = 13;
   localparam int FDSM_HI_W         = 5;
   localparam int FDSM_DWELL_W      = 16;
   localparam int FDSM_PER_W        = 24;
   localparam int FDSM_MAG_W        = 13;
   localparam int FDSM_IRQ_W        = 4;
   // interrupt status bits
   localparam int FDSM_IRQ_FLAG_SET = 0;
   localparam int FDSM_IRQ_FLAG_CLR = 1;
   localparam int FDSM_IRQ_PERIOD   = 2;
   localparam int FDSM_IRQ_SYNC     = 3;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  FDSM_RST_PER0 = 8'h80;
   localparam logic [7:0]  FDSM_RST_BYTE = 8'h00;
   localparam logic [31:0] FDSM_RD_ZERO  = 32'h0000_0000;
endpackage

// File: design/fdsm_fast_detect.sv
// fast detect comparator with dwell release and force override
// assumes magnitude samples valid on every core_clk edge
`timescale 1ns/1ps
module fdsm_fast_detect
   import fdsm_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   input  wire logic                    fd_enable,
   input  wire logic                    force_en,
   input  wire logic                    force_val,
   input  wire logic [FDSM_THR_W-1:0]   upper_thr,
   input  wire logic [FDSM_THR_W-1:0]   lower_thr,
   input  wire logic [FDSM_DWELL_W-1:0] dwell_load,
   input  wire logic [FDSM_MAG_W-1:0]   fine_mag,
   output logic                         threshold_flag_pin,
   output logic                         det_ff
);
   logic [FDSM_DWELL_W-1:0] dwell_ff;

   // ---------------------------------------------------------------
   // detection state and dwell counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         det_ff   <= 1'b0;
         dwell_ff <= '0;
      end else if (!fd_enable) begin
         det_ff   <= 1'b0; // function disabled [RL1]
         dwell_ff <= '0;
      end else if (fine_mag > upper_thr) begin
         det_ff   <= 1'b1; // over upper threshold [RL2] [RL16]
         dwell_ff <= dwell_load;
      end else if (det_ff && fine_mag < lower_thr) begin
         // count down below lower threshold [RL3] [RL4]
         if (dwell_ff == '0) begin
            det_ff <= 1'b0;
         end else begin
            dwell_ff <= dwell_ff - 1'b1;
         end
      end else begin
         dwell_ff <= dwell_load; // dwell restarts when not below lower [RL4]
      end
   end

   // pin output, registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         threshold_flag_pin <= 1'b0;
      end else begin
         threshold_flag_pin <= fd_enable & (force_en ? force_val : det_ff); // [RL1] [RL14]
      end
   end
endmodule

// File: design/fdsm_monitor.sv
// signal monitor: period counter, peak detector, sysref alignment
// assumes sysref is synchronous to core_clk
`timescale 1ns/1ps
module fdsm_monitor
   import fdsm_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  peak_en,
   input  wire logic [FDSM_PER_W-1:0] period,
   input  wire logic                  sync_pulse,
   input  wire logic [FDSM_MAG_W-1:0] fine_mag,
   output logic [FDSM_MAG_W-1:0]      peak_ff,
   output logic                       expire
);
   logic [FDSM_PER_W-1:0] cnt_ff;
   logic [FDSM_MAG_W-1:0] track_ff;

   assign expire = peak_en && (cnt_ff + 1'b1 >= period);

   // ---------------------------------------------------------------
   // period counter, cleared by sync
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (!peak_en || sync_pulse || expire) begin
         cnt_ff <= '0; // [RL11] [RL5] [RL12]
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // peak tracking with capture at expiry
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         track_ff <= '0;
         peak_ff  <= '0;
      end else if (!peak_en || sync_pulse) begin
         track_ff <= '0; // [RL11]
      end else if (expire) begin
         peak_ff  <= (fine_mag > track_ff) ? fine_mag : track_ff; // [RL17]
         track_ff <= '0;
      end else if (fine_mag > track_ff) begin
         track_ff <= fine_mag; // [RL17]
      end
   end
endmodule

// File: design/fdsm_top.sv
// fast detect and signal monitor top with apb register slave
// assumes apb master on core_clk, one register per 32-bit word
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module fdsm_top
   import fdsm_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [FDSM_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [FDSM_MAG_W-1:0]  fine_mag,
   input  wire logic                   sysref,
   output logic                        threshold_flag_pin,
   output logic                        irq
);
   logic [7:0]              fd_ctrl_ff;
   logic [7:0]              up_lo_ff;
   logic [FDSM_HI_W-1:0]    up_hi_ff;
   logic [7:0]              lo_lo_ff;
   logic [FDSM_HI_W-1:0]    lo_hi_ff;
   logic [7:0]              dw_lo_ff;
   logic [7:0]              dw_hi_ff;
   logic                    sync_en_ff;
   logic                    sync_next_ff;
   logic                    peak_en_ff;
   logic [7:0]              per0_ff;
   logic [7:0]              per1_ff;
   logic [7:0]              per2_ff;
   logic [FDSM_IRQ_W-1:0]   irq_stat_ff;
   logic [FDSM_IRQ_W-1:0]   irq_en_ff;
   logic                    sysref_d_ff;
   logic                    det_prev_ff;
   logic                    det;
   logic                    sys_edge;
   logic                    sync_pulse;
   logic                    expire;
   logic [FDSM_MAG_W-1:0]   peak;
   logic                    wr;
   logic                    rd;
   logic                    hit;
   logic [FDSM_IDX_W-1:0]   idx;
   logic [FDSM_IRQ_W-1:0]   ev;
   logic [31:0]             nxt_rdata;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   assign idx    = paddr[FDSM_ADDR_W-1:2];
   assign wr     = psel && penable && pwrite;
   assign rd     = psel && penable && !pwrite;
   assign pready = 1'b1; // zero wait states

   // address hit check
   always_comb begin
      unique case (idx)
         FDSM_IDX_FD_CTRL, FDSM_IDX_UP_LO, FDSM_IDX_UP_HI, FDSM_IDX_LO_LO,
         FDSM_IDX_LO_HI, FDSM_IDX_DW_LO, FDSM_IDX_DW_HI, FDSM_IDX_SYNC_CTRL,
         FDSM_IDX_MON_CTRL, FDSM_IDX_PER0, FDSM_IDX_PER1, FDSM_IDX_PER2,
         FDSM_IDX_PEAK, FDSM_IDX_IRQ_STAT, FDSM_IDX_IRQ_EN,
         FDSM_IDX_IRQ_CLR: hit = 1'b1;
         default:          hit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !hit;

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fd_ctrl_ff <= FDSM_RST_BYTE;
         up_lo_ff   <= FDSM_RST_BYTE;
         up_hi_ff   <= '0;
         lo_lo_ff   <= FDSM_RST_BYTE;
         lo_hi_ff   <= '0;
         dw_lo_ff   <= FDSM_RST_BYTE;
         dw_hi_ff   <= FDSM_RST_BYTE;
         peak_en_ff <= 1'b0;
         per0_ff    <= FDSM_RST_PER0; // [RL12]
         per1_ff    <= FDSM_RST_BYTE;
         per2_ff    <= FDSM_RST_BYTE;
         irq_en_ff  <= '0;
      end else if (wr) begin
         unique case (idx)
            FDSM_IDX_FD_CTRL: begin
               fd_ctrl_ff <= {4'h0, pwdata[FDSM_FORCE_BIT], pwdata[FDSM_FORCE_VAL_BIT],
                              1'b0, pwdata[FDSM_FD_EN_BIT]};
            end
            FDSM_IDX_UP_LO:  up_lo_ff   <= pwdata[7:0];
            FDSM_IDX_UP_HI:  up_hi_ff   <= pwdata[FDSM_HI_W-1:0]; // [RL2]
            FDSM_IDX_LO_LO:  lo_lo_ff   <= pwdata[7:0];
            FDSM_IDX_LO_HI:  lo_hi_ff   <= pwdata[FDSM_HI_W-1:0]; // [RL3]
            FDSM_IDX_DW_LO:  dw_lo_ff   <= pwdata[7:0];
            FDSM_IDX_DW_HI:  dw_hi_ff   <= pwdata[7:0];
            FDSM_IDX_MON_CTRL: peak_en_ff <= pwdata[FDSM_PEAK_EN_BIT]; // [RL11]
            FDSM_IDX_PER0:   per0_ff    <= pwdata[7:0];
            FDSM_IDX_PER1:   per1_ff    <= pwdata[7:0]; // [RL15]
            FDSM_IDX_PER2:   per2_ff    <= pwdata[7:0]; // [RL15]
            FDSM_IDX_IRQ_EN: irq_en_ff  <= pwdata[FDSM_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // sysref alignment
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sysref_d_ff <= 1'b0;
      end else begin
         sysref_d_ff <= sysref;
      end
   end
   assign sys_edge   = sysref && !sysref_d_ff;
   assign sync_pulse = sys_edge && sync_en_ff; // [RL5] [RL8] [RL6]

   // sync control; hardware clear wins over a same-cycle write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_en_ff   <= 1'b0;
         sync_next_ff <= 1'b0;
      end else begin
         if (wr && idx == FDSM_IDX_SYNC_CTRL) begin
            sync_next_ff <= pwdata[FDSM_SYNC_NEXT_BIT];
         end
         if (sync_pulse && sync_next_ff) begin
            sync_en_ff <= 1'b0; // one-shot disarm [RL6] [RL7]
         end else if (wr && idx == FDSM_IDX_SYNC_CTRL) begin
            sync_en_ff <= pwdata[FDSM_SYNC_EN_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // sub-blocks
   // ---------------------------------------------------------------
   fdsm_fast_detect u_fd (
      .core_clk           (core_clk),
      .rst                (rst),
      .fd_enable          (fd_ctrl_ff[FDSM_FD_EN_BIT]),
      .force_en           (fd_ctrl_ff[FDSM_FORCE_BIT]),
      .force_val          (fd_ctrl_ff[FDSM_FORCE_VAL_BIT]),
      .upper_thr          ({up_hi_ff, up_lo_ff}),
      .lower_thr          ({lo_hi_ff, lo_lo_ff}),
      .dwell_load         ({dw_hi_ff, dw_lo_ff}),
      .fine_mag           (fine_mag),
      .threshold_flag_pin (threshold_flag_pin),
      .det_ff             (det)
   );

   fdsm_monitor u_mon (
      .core_clk   (core_clk),
      .rst        (rst),
      .peak_en    (peak_en_ff),
      .period     ({per2_ff, per1_ff, per0_ff}),
      .sync_pulse (sync_pulse),
      .fine_mag   (fine_mag),
      .peak_ff    (peak),
      .expire     (expire)
   );

   // ---------------------------------------------------------------
   // interrupts: sticky status, set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         det_prev_ff <= 1'b0;
      end else begin
         det_prev_ff <= det;
      end
   end

   always_comb begin
      ev = '0;
      ev[FDSM_IRQ_FLAG_SET] = det && !det_prev_ff;
      ev[FDSM_IRQ_FLAG_CLR] = !det && det_prev_ff;
      ev[FDSM_IRQ_PERIOD]   = expire;
      ev[FDSM_IRQ_SYNC]     = sync_pulse;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_stat_ff <= '0;
      end else if (wr && idx == FDSM_IDX_IRQ_CLR) begin
         irq_stat_ff <= (irq_stat_ff & ~pwdata[FDSM_IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_ff <= irq_stat_ff | ev;
      end
   end
   assign irq = |(irq_stat_ff & irq_en_ff);

   // ---------------------------------------------------------------
   // read mux, registered data
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rdata = FDSM_RD_ZERO;
      unique case (idx)
         FDSM_IDX_FD_CTRL:   nxt_rdata[7:0] = fd_ctrl_ff;
         FDSM_IDX_UP_LO:     nxt_rdata[7:0] = up_lo_ff;
         FDSM_IDX_UP_HI:     nxt_rdata[FDSM_HI_W-1:0] = up_hi_ff;
         FDSM_IDX_LO_LO:     nxt_rdata[7:0] = lo_lo_ff;
         FDSM_IDX_LO_HI:     nxt_rdata[FDSM_HI_W-1:0] = lo_hi_ff;
         FDSM_IDX_DW_LO:     nxt_rdata[7:0] = dw_lo_ff;
         FDSM_IDX_DW_HI:     nxt_rdata[7:0] = dw_hi_ff;
         FDSM_IDX_SYNC_CTRL: nxt_rdata[1:0] = {sync_next_ff, sync_en_ff};
         FDSM_IDX_MON_CTRL:  nxt_rdata[FDSM_PEAK_EN_BIT] = peak_en_ff;
         FDSM_IDX_PER0:      nxt_rdata[7:0] = per0_ff;
         FDSM_IDX_PER1:      nxt_rdata[7:0] = per1_ff;
         FDSM_IDX_PER2:      nxt_rdata[7:0] = per2_ff;
         FDSM_IDX_PEAK:      nxt_rdata[FDSM_MAG_W-1:0] = peak;
         FDSM_IDX_IRQ_STAT:  nxt_rdata[FDSM_IRQ_W-1:0] = irq_stat_ff;
         FDSM_IDX_IRQ_EN:    nxt_rdata[FDSM_IRQ_W-1:0] = irq_en_ff;
         default:            nxt_rdata = FDSM_RD_ZERO;
      endcase
   end

   // data captured in the setup cycle, stable through access
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= FDSM_RD_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata <= nxt_rdata;
      end
   end
endmodule

// File: verification/fdsm_props.sv
// checker for fdsm_top: apb answers, flag pin and irq gating
// assumes bind onto fdsm_top; control fields shadowed from apb writes
`timescale 1ns/1ps
module fdsm_props
   import fdsm_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [FDSM_ADDR_W-1:0] paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [FDSM_MAG_W-1:0]  fine_mag,
   input wire logic                   threshold_flag_pin,
   input wire logic                   irq
);
   logic [11:0] ix;
   logic        mapped, en_ff, frc_ff, fv_ff;
   logic [12:0] up_ff, lo_ff;
   logic [3:0]  ie_ff;
   // register index and map decode
   assign ix = paddr[13:2];
   assign mapped = ix inside {12'h245, [12'h247:12'h24C], [12'h26F:12'h273], [12'h280:12'h283]};
   // shadow of the fields the flag and irq relations depend on
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {en_ff, frc_ff, fv_ff, ie_ff, up_ff, lo_ff} <= 33'h0;
      end else if (psel && penable && pwrite) begin
         case (ix)
            12'h245: {frc_ff, fv_ff, en_ff} <= {pwdata[3:2], pwdata[0]};
            12'h247: up_ff[7:0] <= pwdata[7:0];
            12'h248: up_ff[12:8] <= pwdata[4:0];
            12'h249: lo_ff[7:0] <= pwdata[7:0];
            12'h24A: lo_ff[12:8] <= pwdata[4:0];
            12'h282: ie_ff <= pwdata[3:0];
            default: ;
         endcase
      end
   end
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   // above upper while enabled, still enabled a cycle later
   sequence s_over;
      (en_ff && !frc_ff && fine_mag > up_ff) ##1 (en_ff && !frc_ff);
   endsequence
   // flag falls after two unforced, enabled cycles
   sequence s_fall;
      $fell(threshold_flag_pin) && $past(en_ff) && !$past(frc_ff) && $past(en_ff, 2)
         && !$past(frc_ff, 2);
   endsequence
   zero_wait_a: assert property (pready) else $error("pready low");
   slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr wrong");
   unmapped_rd_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   flag_off_a: assert property (!en_ff |=> !threshold_flag_pin)
      else $error("flag driven while disabled");
   flag_force_a: assert property (en_ff && frc_ff |=> threshold_flag_pin == $past(fv_ff))
      else $error("forced flag wrong");
   flag_set_a: assert property (s_over |=> threshold_flag_pin)
      else $error("flag not set above upper");
   flag_release_a: assert property (s_fall |-> $past(fine_mag, 2) < $past(lo_ff, 2))
      else $error("flag released while not below lower");
   irq_mask_a: assert property (ie_ff == 4'h0 |-> !irq) else $error("irq while masked");
endmodule
bind fdsm_top fdsm_props u_props (.core_clk(core_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fine_mag(fine_mag),
   .threshold_flag_pin(threshold_flag_pin), .irq(irq));

// File: verification/fdsm_host.sv
// host-side model: magnitude source, sysref source, flag pin watcher
// assumes the bench requests samples and edges on core_clk
`timescale 1ns/1ps
module fdsm_host
   import fdsm_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic [FDSM_MAG_W-1:0] mag_req,
   input  wire logic                  edge_req,
   input  wire logic                  threshold_flag_pin,
   output logic [FDSM_MAG_W-1:0]      fine_mag,
   output logic                       sysref,
   output logic [7:0]                 flag_rises
);
   logic       pend_ff, flag_ff;
   logic [2:0] phase_ff;
   // edges leave on an eight-cycle grid, a multiple of the period
   // first and third edges requested while sync is disabled, the others after the bench enabled sync
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {pend_ff, sysref, phase_ff} <= 5'h00;
      end else begin
         phase_ff <= phase_ff + 3'h1;
         pend_ff  <= (pend_ff | edge_req) & (phase_ff != 3'h7);
         sysref   <= (pend_ff | edge_req) & (phase_ff == 3'h7);
      end
   end
   // sample source and count of flag assertions seen by the host
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {fine_mag, flag_ff, flag_rises} <= 22'h0;
      end else begin
         fine_mag   <= mag_req;
         flag_ff    <= threshold_flag_pin;
         flag_rises <= flag_rises + {7'h0, threshold_flag_pin & ~flag_ff};
      end
   end
endmodule

// File: verification/fdsm_top_tb.sv
// testbench for fdsm_top: registers, fast detect, monitor and sync
// assumes fdsm_host on the far side and the bound checker
`timescale 1ns/1ps
module fdsm_top_tb
   import fdsm_pkg::*;
;
   logic                   core_clk, rst, psel, penable, pwrite, edge_req, pready;
   logic                   pslverr, e, flag, irq, sysref;
   logic [FDSM_ADDR_W-1:0] paddr;
   logic [31:0]            pwdata, prdata, q;
   logic [FDSM_MAG_W-1:0]  mag_req, fine_mag;
   logic [7:0]             rises;
   logic [11:0]            ix [16] = '{12'h245, 12'h247, 12'h248, 12'h249, 12'h24A,
      12'h24B, 12'h24C, 12'h26F, 12'h270, 12'h271, 12'h272, 12'h273, 12'h280, 12'h281,
      12'h282, 12'h283};
   int                     bad_count, comparisons;
   fdsm_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fine_mag(fine_mag), .sysref(sysref),
      .threshold_flag_pin(flag), .irq(irq));
   fdsm_host host (.core_clk(core_clk), .rst(rst), .mag_req(mag_req), .edge_req(edge_req),
      .threshold_flag_pin(flag), .fine_mag(fine_mag), .sysref(sysref), .flag_rises(rises));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready, then an idle cycle
   task automatic acc(input logic w, input logic [11:0] i, input logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, i, 2'h0, d};
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      acc(1'h1, i, d);
   endtask
   task automatic rdc(input logic [11:0] i, input logic [31:0] x, input logic [31:0] m = '1);
      acc(1'h0, i, 32'h0);
      chk(q & m, x);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic pulse();
      edge_req <= 1'h1;
      cyc(1);
      edge_req <= 1'h0;
      cyc(14);
   endtask
   task automatic conclude();
      $display("compared %0d, mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial forever #5 core_clk = ~core_clk;
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("Error %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      {core_clk, rst, psel, penable, pwrite, edge_req, paddr, pwdata, mag_req} = '0;
      rst = 1'h1;
      cyc(20);
      rst <= 1'h0;
      cyc(1);
      foreach (ix[k]) rdc(ix[k], (ix[k] == 12'h271) ? 32'h80 : 32'h0);
      acc(1'h0, 12'h246, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(12'h281, 32'hF);
      rdc(12'h281, 32'h0);
      $display("reset and map test done");
      wr(12'h248, 32'hE1);
      rdc(12'h248, 32'h01);
      wr(12'h249, 32'h80);
      wr(12'h24A, 32'hE0);
      rdc(12'h24A, 32'h00);
      wr(12'h24C, 32'hA5);
      rdc(12'h24C, 32'hA5);
      wr(12'h24C, 32'h0);
      wr(12'h24B, 32'h3);
      wr(12'h282, 32'h3);
      mag_req <= 13'h0100;
      wr(12'h245, 32'h1);
      cyc(6);
      chk(flag, 32'h0);
      mag_req <= 13'h0101;
      cyc(5);
      chk({rises, irq, flag}, 32'h7);
      mag_req <= 13'h0050;
      cyc(3);
      chk(flag, 32'h1);
      cyc(12);
      chk(flag, 32'h0);
      rdc(12'h281, 32'h3);
      wr(12'h283, 32'h1);
      rdc(12'h281, 32'h2);
      chk(irq, 32'h1);
      wr(12'h282, 32'h1);
      chk(irq, 32'h0);
      wr(12'h245, 32'h0);
      mag_req <= 13'h0101;
      cyc(6);
      chk(flag, 32'h0);
      wr(12'h245, 32'hD);
      cyc(2);
      chk(flag, 32'h1);
      wr(12'h245, 32'h9);
      cyc(2);
      chk(flag, 32'h0);
      mag_req <= 13'h0000;
      wr(12'h245, 32'h1);
      cyc(20);
      wr(12'h283, 32'hF);
      $display("fast detect test done");
      wr(12'h272, 32'h12);
      wr(12'h273, 32'h34);
      rdc(12'h272, 32'h12);
      rdc(12'h273, 32'h34);
      wr(12'h272, 32'h0);
      wr(12'h273, 32'h0);
      wr(12'h271, 32'h8);
      wr(12'h270, 32'h2);
      for (int k = 0; k < 24; k++) begin
         mag_req <= k[0] ? 13'h0123 : 13'h0040;
         cyc(1);
      end
      rdc(12'h280, 32'h123);
      mag_req <= 13'h0040;
      cyc(30);
      rdc(12'h280, 32'h40);
      rdc(12'h281, 32'h7);
      wr(12'h270, 32'h0);
      wr(12'h283, 32'hF);
      cyc(20);
      rdc(12'h281, 32'h0);
      $display("monitor test done");
      wr(12'h270, 32'h2);
      pulse();
      rdc(12'h281, 32'h0, 32'h8);
      wr(12'h26F, 32'h3);
      pulse();
      rdc(12'h26F, 32'h2);
      rdc(12'h281, 32'h8, 32'h8);
      wr(12'h283, 32'h8);
      pulse();
      rdc(12'h281, 32'h0, 32'h8);
      wr(12'h26F, 32'h1);
      repeat (2) begin
         wr(12'h283, 32'h8);
         pulse();
         rdc(12'h281, 32'h8, 32'h8);
      end
      rdc(12'h26F, 32'h1);
      $display("sync test done");
      conclude();
   end
endmodule
